// ==== rtl/fqc_top.sv ====
`timescale 1ns/1ns
module fqc_top
  import fqc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [21:0]      fl_addr,
  output logic [15:0]      fl_dq_out,
  input  wire logic [15:0] fl_dq_in,
  output logic             fl_dq_oe_n,
  output logic             fl_ce_n,
  output logic             fl_oe_n,
  output logic             fl_we_n,
  output logic             fl_byte_n
);

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_RUN  = 2'b10
  } fqc_st_t;

  fqc_cyc_if cyc ();

  fqc_st_t     st_q;
  fqc_op_t     op_q;
  logic [1:0]  idx_q;
  logic        req_q;
  logic        byte_q;
  logic [21:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic        id_q, cfi_q, sec_q, prev_id_q;
  logic        err_q, fail_q, locked_q, prot_q;

  // ----------------------------------------
  // Command steps
  // ----------------------------------------
  function automatic fqc_step_t step_of(fqc_op_t op, logic [1:0] i, logic bm, logic [21:0] a, logic [15:0] d);
    fqc_step_t s;
    logic [21:0] u1;
    logic [21:0] u2;
    u1 = bm ? UNL1_B : UNL1_W;
    u2 = bm ? UNL2_B : UNL2_W;
    s  = '{last: 1'b1, wr: 1'b1, addr: a, data: d};
    case (op)
      OP_ID, OP_SEC_EN, OP_SEC_EX:
      begin
        s.last = (op == OP_SEC_EX) ? (i == 2'h3) : (i == 2'h2);
        s.addr = (i == 2'h1) ? u2 : ((i == 2'h3) ? 22'h000000 : u1);
        s.data = (i == 2'h0) ? D_UNL1 : (i == 2'h1) ? D_UNL2 : (i == 2'h3) ? D_EXIT2 :
                 (op == OP_SEC_EN) ? D_SEC_EN : D_ID;
      end
      OP_RESET:
      begin
        s.addr = 22'h000000;
        s.data = D_RESET;
      end
      OP_CFI:
      begin
        s.addr = bm ? CFI_B : CFI_W;
        s.data = D_CFI;
      end
      OP_READ:
        s.wr = 1'b0;
      default:
        s.last = 1'b1;
    endcase
    return s;
  endfunction : step_of

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire        apb_acc   = psel && penable && !pready;
  wire        apb_wr    = apb_acc && pwrite;
  wire        hit       = (paddr == REG_CTRL) || (paddr == REG_STATUS) || (paddr == REG_ADDR) ||
                          (paddr == REG_WDATA) || (paddr == REG_RDATA);
  wire        ctrl_wr   = apb_wr && (paddr == REG_CTRL);
  wire fqc_op_t new_op  = fqc_op_t'(pwdata[2:0]);
  wire        idle      = (st_q == S_IDLE);
  wire        only_rst  = cfi_q || fail_q;
  wire        refuse    = (new_op == OP_CFI && (cfi_q || sec_q)) ||
                          (new_op == OP_SEC_EX && !sec_q) ||
                          (only_rst && new_op != OP_RESET && new_op != OP_READ) ||
                          (id_q && new_op != OP_RESET && new_op != OP_READ && new_op != OP_CFI);
  wire        start     = ctrl_wr && new_op != OP_NONE && idle && !refuse;
  wire        bad_cmd   = ctrl_wr && new_op != OP_NONE && !start;
  wire fqc_step_t stp   = step_of(op_q, idx_q, byte_q, addr_q, wdata_q);
  wire        fin       = (st_q == S_RUN) && cyc.done && stp.last;
  wire [1:0]  wlow      = byte_q ? addr_q[2:1] : addr_q[1:0];
  wire        err_clr   = apb_wr && (paddr == REG_STATUS) && pwdata[ST_ERR];
  wire [31:0] status_w  = {24'h000000, prot_q, locked_q, fail_q, err_q, sec_q, cfi_q, id_q, !idle};
  wire [31:0] rd_mux    = (paddr == REG_CTRL)   ? {23'h000000, byte_q, 8'h00} :
                          (paddr == REG_STATUS) ? status_w :
                          (paddr == REG_ADDR)   ? {10'h000, addr_q} :
                          (paddr == REG_WDATA)  ? {16'h0000, wdata_q} :
                          (paddr == REG_RDATA)  ? {16'h0000, rdata_q} : 32'h00000000;

  assign cyc.req   = req_q;
  assign cyc.wr    = stp.wr;
  assign cyc.addr  = stp.addr;
  assign cyc.wdata = stp.data;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h00000000;
      byte_q    <= 1'b0;
      fl_byte_n <= 1'b1;
      addr_q    <= 22'h000000;
      wdata_q   <= 16'h0000;
    end
    else
    begin
      pready  <= apb_acc;
      pslverr <= apb_acc && !hit;
      prdata  <= (apb_acc && !pwrite) ? rd_mux : 32'h00000000;
      if (ctrl_wr && idle)
      begin
        byte_q    <= pwdata[CTRL_BYTE_POS];
        fl_byte_n <= !pwdata[CTRL_BYTE_POS];
      end
      if (apb_wr && paddr == REG_ADDR && idle)
        addr_q <= pwdata[21:0];
      if (apb_wr && paddr == REG_WDATA && idle)
        wdata_q <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q  <= S_IDLE;
      op_q  <= OP_NONE;
      idx_q <= 2'h0;
      req_q <= 1'b0;
    end
    else
    begin
      req_q <= 1'b0;
      case (st_q)
        S_IDLE:
        begin
          if (start)
          begin
            st_q  <= S_RUN;
            op_q  <= new_op;
            idx_q <= 2'h0;
            req_q <= 1'b1;
          end
        end
        S_RUN:
        begin
          if (cyc.done)
          begin
            idx_q <= idx_q + 2'h1;
            req_q <= !stp.last;
            st_q  <= stp.last ? S_IDLE : S_RUN;
          end
        end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Mode tracking and results
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      id_q      <= 1'b0;
      cfi_q     <= 1'b0;
      sec_q     <= 1'b0;
      prev_id_q <= 1'b0;
      err_q     <= 1'b0;
      fail_q    <= 1'b0;
      locked_q  <= 1'b0;
      prot_q    <= 1'b0;
      rdata_q   <= 16'h0000;
    end
    else
    begin
      // Set wins over clear
      err_q <= bad_cmd || (err_q && !err_clr);
      if (fin)
      begin
        case (op_q)
          OP_ID:
            id_q <= 1'b1;
          OP_RESET:
          begin
            id_q   <= cfi_q ? prev_id_q : 1'b0;
            cfi_q  <= 1'b0;
            fail_q <= 1'b0;
          end
          OP_CFI:
          begin
            cfi_q     <= 1'b1;
            prev_id_q <= id_q;
            id_q      <= 1'b0;
          end
          OP_SEC_EN:
            sec_q <= 1'b1;
          OP_SEC_EX:
            sec_q <= 1'b0;
          OP_READ:
          begin
            rdata_q <= cyc.rdata;
            if (id_q && wlow == ID_LOCK_ADDR)
              locked_q <= cyc.rdata[ID_LOCK_BIT];
            if (id_q && wlow == ID_PROT_ADDR)
              prot_q <= cyc.rdata[PROT_BIT];
            if (!id_q && !cfi_q && !sec_q && cyc.rdata[FAIL_BIT])
              fail_q <= 1'b1;
          end
          default:
            rdata_q <= rdata_q;
        endcase
      end
    end
  end

  fqc_cycle u_cycle (
    .pclk       (pclk),
    .presetn    (presetn),
    .cyc        (cyc.engine),
    .fl_addr    (fl_addr),
    .fl_dq_out  (fl_dq_out),
    .fl_dq_in   (fl_dq_in),
    .fl_dq_oe_n (fl_dq_oe_n),
    .fl_ce_n    (fl_ce_n),
    .fl_oe_n    (fl_oe_n),
    .fl_we_n    (fl_we_n)
  );

  cfi_refused_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_wr && new_op == OP_CFI && (cfi_q || sec_q) |=> err_q && idle)
    else $error("query command not refused");
  exit_refused_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_wr && new_op == OP_SEC_EX && !sec_q |=> err_q && !req_q)
    else $error("exit issued outside region");
  query_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    req_q && op_q == OP_CFI |-> cyc.addr == (byte_q ? CFI_B : CFI_W) && cyc.wdata == D_CFI)
    else $error("query command at wrong address");
  id_third_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(id_q) && !$past(cfi_q) |-> $past(op_q) == OP_ID && $past(idx_q) == 2'h2 && $past(cyc.wdata) == D_ID)
    else $error("id mode without 90h third write");
  exit_four_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(sec_q) |-> $past(idx_q) == 2'h3 && $past(op_q) == OP_SEC_EX)
    else $error("region left without four writes");
  cfi_return_a: assert property (@(posedge pclk) disable iff (!presetn)
    fin && op_q == OP_RESET && cfi_q |=> !cfi_q && id_q == $past(prev_id_q))
    else $error("query reset to wrong mode");
  id_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
    fin && op_q == OP_RESET && !cfi_q |=> !id_q && !fail_q)
    else $error("reset left id mode or failure set");
  fail_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    fail_q && !(fin && op_q == OP_RESET) |=> fail_q)
    else $error("failure cleared without reset");
  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one cycle");

  id_entry_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(id_q));
  cfi_from_id_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(cfi_q) && prev_id_q);
  sec_round_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(sec_q));
  fail_reset_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(fail_q));

endmodule : fqc_top

// ==== rtl/fqc_pkg.sv ====
package fqc_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_WDATA  = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;

  localparam int CTRL_BYTE_POS = 8;
  localparam int ST_BUSY       = 0;
  localparam int ST_ID         = 1;
  localparam int ST_CFI        = 2;
  localparam int ST_SEC        = 3;
  localparam int ST_ERR        = 4;
  localparam int ST_FAIL       = 5;
  localparam int ST_LOCKED     = 6;
  localparam int ST_PROT       = 7;
  localparam int ID_LOCK_BIT   = 7;
  localparam int FAIL_BIT      = 5;
  localparam int PROT_BIT      = 0;

  // ----------------------------------------
  // Flash command words
  // ----------------------------------------
  localparam logic [21:0] UNL1_W   = 22'h000555;
  localparam logic [21:0] UNL2_W   = 22'h0002aa;
  localparam logic [21:0] UNL1_B   = 22'h000aaa;
  localparam logic [21:0] UNL2_B   = 22'h000555;
  localparam logic [21:0] CFI_W    = 22'h000055;
  localparam logic [21:0] CFI_B    = 22'h0000aa;
  localparam logic [15:0] D_UNL1   = 16'h00aa;
  localparam logic [15:0] D_UNL2   = 16'h0055;
  localparam logic [15:0] D_ID     = 16'h0090;
  localparam logic [15:0] D_RESET  = 16'h00f0;
  localparam logic [15:0] D_CFI    = 16'h0098;
  localparam logic [15:0] D_SEC_EN = 16'h0088;
  localparam logic [15:0] D_EXIT2  = 16'h0000;
  localparam logic [1:0]  ID_LOCK_ADDR = 2'h3;
  localparam logic [1:0]  ID_PROT_ADDR = 2'h2;

  // ----------------------------------------
  // Pin timing
  // ----------------------------------------
  localparam int CLK_NS    = 20;
  localparam int T_WP_NS   = 35;
  localparam int T_ACC_NS  = 70;
  localparam int SYNC_CYC  = 2;
  localparam int WE_CYC    = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC    = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;

  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_READ   = 3'h1,
    OP_WRITE  = 3'h2,
    OP_ID     = 3'h3,
    OP_RESET  = 3'h4,
    OP_CFI    = 3'h5,
    OP_SEC_EN = 3'h6,
    OP_SEC_EX = 3'h7
  } fqc_op_t;

  typedef struct packed {
    logic        last;
    logic        wr;
    logic [21:0] addr;
    logic [15:0] data;
  } fqc_step_t;

endpackage : fqc_pkg

// ==== rtl/fqc_cyc_if.sv ====
`timescale 1ns/1ns
interface fqc_cyc_if;
  logic        req;
  logic        wr;
  logic [21:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;

  modport master (output req, output wr, output addr, output wdata, input done, input rdata);
  modport engine (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : fqc_cyc_if

// ==== rtl/fqc_cycle.sv ====
`timescale 1ns/1ns
module fqc_cycle
  import fqc_pkg::*;
#(
  parameter int WE_CYCLES = WE_CYC,
  parameter int RD_CYCLES = RD_CYC
)(
  input  wire logic  pclk,
  input  wire logic  presetn,
  fqc_cyc_if.engine  cyc,
  output logic [21:0] fl_addr,
  output logic [15:0] fl_dq_out,
  input  wire logic [15:0] fl_dq_in,
  output logic        fl_dq_oe_n,
  output logic        fl_ce_n,
  output logic        fl_oe_n,
  output logic        fl_we_n
);

  if (WE_CYCLES < 1 || WE_CYCLES > 255 || RD_CYCLES < SYNC_CYC + 1 || RD_CYCLES > 255)
  begin : g_chk
    $error("fqc_cycle: pulse counts out of range");
  end

  typedef enum logic [3:0] {
    C_IDLE  = 4'b0001,
    C_SETUP = 4'b0010,
    C_PULSE = 4'b0100,
    C_DONE  = 4'b1000
  } fqc_cst_t;

  fqc_cst_t    st_q;
  logic [7:0]  cnt_q;
  logic        wr_q;
  logic [15:0] sync1_q;
  logic [15:0] sync2_q;
  logic        done_q;
  logic [15:0] rdata_q;

  wire        accept  = (st_q == C_IDLE) && cyc.req;
  wire        pul_end = (st_q == C_PULSE) && (cnt_q == 8'h01);
  wire [7:0]  pul_len = wr_q ? WE_CYCLES[7:0] : RD_CYCLES[7:0];

  assign cyc.done  = done_q;
  assign cyc.rdata = rdata_q;

  // ----------------------------------------
  // Data pin synchroniser
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
    end
    else
    begin
      sync1_q <= fl_dq_in;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------
  // One bus cycle
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q       <= C_IDLE;
      cnt_q      <= 8'h00;
      wr_q       <= 1'b0;
      fl_addr    <= 22'h000000;
      fl_dq_out  <= 16'h0000;
      fl_dq_oe_n <= 1'b1;
      fl_ce_n    <= 1'b1;
      fl_oe_n    <= 1'b1;
      fl_we_n    <= 1'b1;
      done_q     <= 1'b0;
      rdata_q    <= 16'h0000;
    end
    else
    begin
      done_q <= 1'b0;
      case (st_q)
        C_IDLE:
        begin
          if (accept)
          begin
            st_q       <= C_SETUP;
            wr_q       <= cyc.wr;
            fl_addr    <= cyc.addr;
            fl_dq_out  <= cyc.wdata;
            fl_dq_oe_n <= !cyc.wr;
            fl_ce_n    <= 1'b0;
          end
        end
        C_SETUP:
        begin
          st_q    <= C_PULSE;
          cnt_q   <= pul_len;
          fl_we_n <= !wr_q;
          fl_oe_n <= wr_q;
        end
        C_PULSE:
        begin
          cnt_q <= cnt_q - 8'h01;
          if (pul_end)
          begin
            st_q    <= C_DONE;
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
            rdata_q <= wr_q ? rdata_q : sync2_q;
          end
        end
        C_DONE:
        begin
          st_q       <= C_IDLE;
          fl_ce_n    <= 1'b1;
          fl_dq_oe_n <= 1'b1;
          done_q     <= 1'b1;
        end
        default:
          st_q <= C_IDLE;
      endcase
    end
  end

  we_pulse_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(fl_we_n) |-> (!fl_we_n)[*2] ##0 !fl_dq_oe_n)
    else $error("write strobe shorter than two cycles or data not driven");

  strobe_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(!fl_we_n && !fl_oe_n) && (!fl_ce_n || (fl_we_n && fl_oe_n)))
    else $error("strobes overlap or active without chip enable");

endmodule : fqc_cycle

// ==== testbench/fqc_flash_model.sv ====
`timescale 1ns/1ns
module fqc_flash_model
  import fqc_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h3c, // Arbitrary value
  parameter logic [7:0] PART_ID  = 8'h5e, // Arbitrary value
  parameter logic       LOCKED   = 1'b1,
  parameter logic       TOP_BOOT = 1'b0
)(
  input  wire logic [21:0] fl_addr,
  input  wire logic [15:0] fl_dq_out,
  output logic [15:0]      fl_dq_in,
  input  wire logic        fl_dq_oe_n,
  input  wire logic        fl_ce_n,
  input  wire logic        fl_oe_n,
  input  wire logic        fl_we_n,
  input  wire logic        fl_byte_n,
  input  wire logic        fail_req
);
  // ----------------------------------------
  // Command state
  // ----------------------------------------
  logic [1:0]  cyc_q  = 2'h0;
  logic        id_q   = 1'b0;
  logic        cfi_q  = 1'b0;
  logic        sec_q  = 1'b0;
  logic        fail_q = 1'b0;
  logic        exit_q = 1'b0;
  logic [15:0] id_store;
  logic [15:0] rd;
  logic [21:0] wa;
  logic [7:0]  d;
  logic        u1;
  logic        u2;
  logic        qa;
  logic [21:0] so;

  assign id_store = {PART_ID, MAKER_ID};
  assign wa = fl_byte_n ? fl_addr : {1'b0, fl_addr[21:1]};
  assign d  = fl_dq_out[7:0];
  assign u1 = fl_addr == (fl_byte_n ? UNL1_W : UNL1_B);
  assign u2 = fl_addr == (fl_byte_n ? UNL2_W : UNL2_B);
  assign qa = fl_addr == (fl_byte_n ? CFI_W : CFI_B);
  // serial number word offset by boot side
  assign so = wa - (TOP_BOOT ? 22'h1f8000 : 22'h000000);

  // command decode at strobe rise, no embedded op runs
  always @(posedge fl_we_n or posedge fail_req)
  begin
    if (!fl_ce_n && cfi_q)
      cfi_q <= (d != 8'hf0);
    else if (!fl_ce_n && d == 8'hf0)
    begin
      id_q   <= 1'b0;
      fail_q <= 1'b0;
      cyc_q  <= 2'h0;
      exit_q <= 1'b0;
    end
    else if (!fl_ce_n && exit_q)
    begin
      sec_q  <= sec_q && d != 8'h00;
      exit_q <= 1'b0;
    end
    else if (!fl_ce_n && d == 8'h98 && qa && cyc_q == 2'h0)
      cfi_q <= 1'b1;
    else if (!fl_ce_n && cyc_q == 2'h0 && d == 8'haa && u1)
      cyc_q <= 2'h1;
    else if (!fl_ce_n && cyc_q == 2'h1 && d == 8'h55 && u2)
      cyc_q <= 2'h2;
    else if (!fl_ce_n)
    begin
      cyc_q  <= 2'h0;
      exit_q <= cyc_q == 2'h2 && u1 && d == 8'h90 && sec_q;
      id_q   <= id_q || (cyc_q == 2'h2 && u1 && d == 8'h90 && !sec_q);
      sec_q  <= sec_q || (cyc_q == 2'h2 && u1 && d == 8'h88);
    end
    else if (fail_req)
      fail_q <= 1'b1;
  end

  always_comb
  begin
    if (cfi_q)
      case (wa)
        22'h10:  rd = 16'h0051;
        22'h11:  rd = 16'h0052;
        22'h12:  rd = 16'h0059;
        22'h13:  rd = 16'h0002;
        22'h15:  rd = 16'h0040;
        default: rd = 16'h0000;
      endcase
    else if (id_q)
      case (wa[1:0])
        2'h0:    rd = {8'h00, id_store[7:0]};
        2'h1:    rd = {8'h00, id_store[15:8]};
        2'h3:    rd = LOCKED ? 16'h0099 : 16'h0019;
        default: rd = {15'h0, wa[12]};
      endcase
    else if (sec_q)
      rd = (so < 22'h8) ? (16'he500 | so[15:0]) : 16'hffff;
    else if (fail_q)
      rd = 16'h0020;
    else
      rd = wa[15:0] & 16'hffdf;
  end

  // Released bus shows inverted data, not a stale value
  assign fl_dq_in = (!fl_ce_n && !fl_oe_n && fl_dq_oe_n) ? rd : ~rd;
endmodule : fqc_flash_model

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  import fqc_pkg::*;

  typedef struct packed {
    logic [2:0]  op;
    logic        bm;
    logic [21:0] a;
    logic [15:0] rd;
    logic [7:0]  st;
  } fqc_row_t;

  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fail_req = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic        pready, pslverr, ev, fl_dq_oe_n, fl_ce_n, fl_oe_n, fl_we_n, fl_byte_n;
  logic [21:0] fl_addr;
  logic [15:0] fl_dq_out, fl_dq_in;
  int          bad_count = 0, samples_checked = 0, cycles = 0;
  fqc_row_t    rows [25];

  fqc_top u_fqc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out), .fl_dq_in(fl_dq_in), .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fl_byte_n(fl_byte_n));
  fqc_flash_model u_fqc_flash_model (.fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_in(fl_dq_in),
    .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_byte_n(fl_byte_n),
    .fail_req(fail_req));

  initial
  begin
    forever #10 pclk = ~pclk;
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic wrap_up;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic do_op(input logic [2:0] op, input logic bm, input logic [21:0] a);
    apb(1'b1, REG_ADDR, {10'h0, a});
    apb(1'b1, REG_CTRL, {23'h0, bm, 5'h0, op});
    rv = 32'h1;
    while (rv[ST_BUSY] !== 1'b0)
      apb(1'b0, REG_STATUS, 32'h0);
  endtask : do_op

  task automatic chk_idle;
    chk("pins", 32'h1f, {27'h0, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe_n, fl_byte_n});
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h0, rv);
  endtask : chk_idle

  // Write strobe only with chip selected and data driven
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      bad_count++;
      wrap_up();
    end
    if (presetn && !fl_we_n && (fl_dq_oe_n || fl_ce_n || !fl_oe_n))
    begin
      bad_count++;
      $display("BAD we_strobe exp qualified got %b%b%b", fl_dq_oe_n, fl_ce_n, fl_oe_n);
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rows = '{'{3'h4, 1'h0, 22'h0, 16'h0, 8'h00}, '{3'h3, 1'h0, 22'h0, 16'h0, 8'h02},
      '{3'h1, 1'h0, 22'h0, 16'h003c, 8'h02}, '{3'h1, 1'h0, 22'h1, 16'h005e, 8'h02},
      '{3'h1, 1'h0, 22'h3, 16'h0099, 8'h42}, '{3'h1, 1'h0, 22'h1002, 16'h0001, 8'hc2},
      '{3'h1, 1'h0, 22'h2, 16'h0000, 8'h42}, '{3'h5, 1'h0, 22'h0, 16'h0, 8'h44},
      '{3'h1, 1'h0, 22'h10, 16'h0051, 8'h44}, '{3'h1, 1'h0, 22'h11, 16'h0052, 8'h44},
      '{3'h1, 1'h0, 22'h12, 16'h0059, 8'h44}, '{3'h1, 1'h0, 22'h15, 16'h0040, 8'h44},
      '{3'h1, 1'h0, 22'h16, 16'h0000, 8'h44}, '{3'h1, 1'h0, 22'h30, 16'h0000, 8'h44},
      '{3'h4, 1'h0, 22'h0, 16'h0, 8'h42}, '{3'h1, 1'h0, 22'h1, 16'h005e, 8'h42},
      '{3'h4, 1'h0, 22'h0, 16'h0, 8'h40}, '{3'h1, 1'h0, 22'h123, 16'h0103, 8'h40},
      '{3'h5, 1'h1, 22'haa, 16'h0, 8'h44}, '{3'h1, 1'h1, 22'h20, 16'h0051, 8'h44},
      '{3'h1, 1'h1, 22'h2a, 16'h0040, 8'h44}, '{3'h4, 1'h1, 22'h0, 16'h0, 8'h40},
      '{3'h6, 1'h0, 22'h0, 16'h0, 8'h48}, '{3'h1, 1'h0, 22'h7, 16'he507, 8'h48},
      '{3'h7, 1'h0, 22'h0, 16'h0, 8'h40}};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_idle();
    foreach (rows[i])
    begin
      do_op(rows[i].op, rows[i].bm, rows[i].a);
      chk("status", {24'h0, rows[i].st}, rv);
      if (rows[i].op == 3'h1)
      begin
        apb(1'b0, REG_RDATA, 32'h0);
        chk("rdata", {16'h0, rows[i].rd}, rv);
      end
    end
    do_op(3'h1, 1'h0, 22'h5);
    apb(1'b0, REG_RDATA, 32'h0);
    chk("array", 32'h5, rv);
    do_op(3'h7, 1'h0, 22'h0);
    chk("exit_refused", 32'h50, rv);
    apb(1'b1, REG_STATUS, 32'h10);
    do_op(3'h5, 1'h0, 22'h0);
    do_op(3'h3, 1'h0, 22'h0);
    chk("cfi_only_reset", 32'h54, rv);
    apb(1'b1, REG_STATUS, 32'h10);
    do_op(3'h5, 1'h0, 22'h0);
    chk("cfi_no_requery", 32'h54, rv);
    apb(1'b1, REG_STATUS, 32'h10);
    do_op(3'h4, 1'h0, 22'h0);
    chk("cfi_left", 32'h40, rv);
    fail_req <= 1'b1;
    @(posedge pclk);
    fail_req <= 1'b0;
    do_op(3'h1, 1'h0, 22'h0);
    chk("fail_set", 32'h60, rv);
    do_op(3'h2, 1'h0, 22'h100);
    chk("fail_hold", 32'h70, rv);
    apb(1'b1, REG_STATUS, 32'h10);
    do_op(3'h4, 1'h0, 22'h0);
    chk("fail_clear", 32'h40, rv);
    do_op(3'h2, 1'h0, 22'h100);
    do_op(3'h1, 1'h0, 22'h9);
    apb(1'b0, REG_RDATA, 32'h0);
    chk("after_fail", 32'h9, rv);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped_rd", 32'h1, {rv[30:0], ev});
    apb(1'b1, 8'h14, 32'hffff);
    chk("unmapped_wr", 32'h1, {31'h0, ev});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_idle();
    wrap_up();
  end
endmodule : tb_top
